// ---- hw/mfs_pkg.sv ----
/*
 * constants, types and register map of the motor fault supervisor.
 * assumes one 125 MHz core clock shared by the supervisor, the adc sample
 * source and the commutation logic.
 */
`default_nettype none

package mfs_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int TICK_PERIOD_NS   = 1000000;  // 1 ms millisecond_tick_timer period
    localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ==========================================================
    // widths
    localparam int ADC_W = 12;
    localparam int DW    = 16;
    localparam int AW    = 4;

    // ==========================================================
    // reset values, supply and current limits in adc counts
    localparam logic [ADC_W-1:0] SUP_LOW_RST   = 12'h2c8;  // 712
    localparam logic [ADC_W-1:0] SUP_HIGH_RST  = 12'h58f;  // 1423
    // counts = amps * 0.007 ohm * 5 V/V / 3.3 V * 4096, 12-bit converter
    localparam logic [ADC_W-1:0] CUR_CEIL_RST  = 12'h12c;  // 300
    localparam logic [DW-1:0]    MIN_REVS_RST  = 16'h0001;
    localparam logic [DW-1:0]    STALL_WIN_RST = 16'h00c8; // 200 ticks
    localparam logic [DW-1:0]    RECOV_RST     = 16'h0bb8; // 3000 ticks
    localparam logic [2:0]       SENSE_GAIN_VV = 3'h5;     // sense_amplifier gain 5 V/V

    // ==========================================================
    // register offsets
    localparam logic [AW-1:0] ADDR_CTRL      = 4'h0;
    localparam logic [AW-1:0] ADDR_SUP_LOW   = 4'h1;
    localparam logic [AW-1:0] ADDR_SUP_HIGH  = 4'h2;
    localparam logic [AW-1:0] ADDR_CUR_CEIL  = 4'h3;
    localparam logic [AW-1:0] ADDR_MIN_REVS  = 4'h4;
    localparam logic [AW-1:0] ADDR_STALL_WIN = 4'h5;
    localparam logic [AW-1:0] ADDR_RECOV     = 4'h6;
    localparam logic [AW-1:0] ADDR_STATUS    = 4'h7;
    localparam logic [AW-1:0] ADDR_INT_STS   = 4'h8;
    localparam logic [AW-1:0] ADDR_INT_MASK  = 4'h9;
    localparam logic [AW-1:0] ADDR_WIN_CNT   = 4'ha;
    localparam logic [AW-1:0] ADDR_REV_CNT   = 4'hb;
    localparam logic [AW-1:0] ADDR_REC_CNT   = 4'hc;

    // ==========================================================
    // field positions
    localparam int CTRL_RUN_BIT   = 0;
    localparam int STS_PREDRV_BIT = 2;
    localparam int IRQ_UV         = 0;
    localparam int IRQ_OV         = 1;
    localparam int IRQ_STALL      = 2;
    localparam int IRQ_OVC        = 3;
    localparam int IRQ_RECOV      = 4;
    localparam int IRQ_W          = 5;
    localparam logic [IRQ_W-1:0] INT_MASK_RST = 5'h00;

    // ==========================================================
    // types
    typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_FAULT} mfs_state_e;

    typedef struct packed {
        logic             valid;
        logic [ADC_W-1:0] data;
    } mfs_sample_s;
endpackage

`default_nettype wire

// ---- hw/mfs_tick_gen.sv ----
/*
 * millisecond_tick_timer: one-cycle tick every CYCLES core clocks.
 * assumes CYCLES of at least 2.
 */
`default_nettype none

module mfs_tick_gen #(
    parameter int unsigned CYCLES = mfs_pkg::TICK_CYCLES_DFLT
) (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    output logic      tick_o
);
    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_r;
    logic          tick_nxt;

    // ==========================================================
    // free-running divider, tick is a flop so it leaves glitch free
    always_comb begin
        cnt_nxt  = (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
        tick_nxt = (cnt_r == LAST);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule

`default_nettype wire

// ---- hw/mfs_supervisor.sv ----
/*
 * motor fault supervisor: supply window, phase-a overcurrent, stall check,
 * timed recovery, register port and interrupt.
 * assumes samples, revolution pulses and the gain ack come from logic on
 * core_clk_i, so none of them is synchronised here.
 */
// Added by the designer: the strobed register port and the placing of the registers.
// Functional notes
// - supply sample below low limit: predrivers off, enter fault
// - supply sample above high limit: predrivers off, enter fault
// - 1 ms tick; stall window counter advances each tick while running
// - count revolutions per window; fewer than minimum means stalled
// - window reaches stall_window_ticks with too few revolutions: stall fault
// - one phase-a current sample per phase-a interval; reaching ceiling is overcurrent
// - current ceiling held in adc counts of the 12-bit converter
// - initialisation sets the sense_amplifier gain to five volts per volt
// - after a fault, reinitialise once recovery_tick_count ticks elapse
`default_nettype none

module mfs_supervisor #(
    parameter int unsigned TICK_CYCLES = mfs_pkg::TICK_CYCLES_DFLT
) (
    input  wire logic                      core_clk_i,
    input  wire logic                      arst_n_i,
    input  wire logic [mfs_pkg::AW-1:0]    reg_addr_i,
    input  wire logic [mfs_pkg::DW-1:0]    reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [mfs_pkg::DW-1:0]    reg_rdata_o,
    input  wire mfs_pkg::mfs_sample_s      supply_smp_i,
    input  wire mfs_pkg::mfs_sample_s      phase_a_smp_i,
    input  wire logic                      phase_a_active_i,
    input  wire logic                      rev_pulse_i,
    output logic      [2:0]                sense_gain_o,
    output logic                           sense_gain_wr_o,
    input  wire logic                      sense_gain_ack_i,
    output logic                           predrv_en_o,
    output logic                           fault_o,
    output logic                           irq_o
);
    localparam int DW = mfs_pkg::DW;
    localparam int AW = mfs_pkg::AW;
    localparam int AD = mfs_pkg::ADC_W;
    localparam int IW = mfs_pkg::IRQ_W;

    function automatic logic [DW-1:0] inc16(input logic [DW-1:0] v);
        return v + 16'h0001;
    endfunction

    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] o);
        return a == o;
    endfunction

    mfs_pkg::mfs_state_e state_r;
    mfs_pkg::mfs_state_e state_nxt;
    logic [DW-1:0] win_r, win_nxt, rev_r, rev_nxt, rec_r, rec_nxt;
    logic          pa_seen_r, pa_seen_nxt, predrv_r, predrv_nxt;
    logic          ev_uv, ev_ov, ev_ovc, ev_stall, ev_rec, take_a, tick;
    logic          run_en_r, run_en_nxt;
    logic [AD-1:0] sup_low_r, sup_low_nxt, sup_high_r, sup_high_nxt;
    logic [AD-1:0] cur_ceil_r, cur_ceil_nxt;
    logic [DW-1:0] min_revs_r, min_revs_nxt, stall_win_r, stall_win_nxt;
    logic [DW-1:0] recov_r, recov_nxt, rdata_r, rdata_nxt;
    logic [IW-1:0] int_sts_r, int_sts_nxt, int_mask_r, int_mask_nxt, ev_vec;

    // ==========================================================
    // tick source
    mfs_tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .tick_o     (tick)
    );

    // ==========================================================
    // supervisor state machine and counters
    always_comb begin
        state_nxt   = state_r;
        win_nxt     = win_r;
        rev_nxt     = rev_r;
        rec_nxt     = rec_r;
        pa_seen_nxt = pa_seen_r;
        ev_uv       = 1'b0;
        ev_ov       = 1'b0;
        ev_ovc      = 1'b0;
        ev_stall    = 1'b0;
        ev_rec      = 1'b0;
        take_a      = 1'b0;
        case (state_r)
            mfs_pkg::ST_INIT: begin
                // gain request held until acked, predrivers stay off
                if (sense_gain_ack_i) begin
                    state_nxt = mfs_pkg::ST_RUN;
                end
            end
            mfs_pkg::ST_RUN: begin
                ev_uv = supply_smp_i.valid && (supply_smp_i.data < sup_low_r);
                ev_ov = supply_smp_i.valid && (supply_smp_i.data > sup_high_r);
                // only the first sample of each phase-a interval is judged
                take_a = phase_a_smp_i.valid && phase_a_active_i && !pa_seen_r;
                ev_ovc = take_a && (phase_a_smp_i.data >= cur_ceil_r);
                if (!phase_a_active_i) begin
                    pa_seen_nxt = 1'b0;
                end else if (take_a) begin
                    pa_seen_nxt = 1'b1;
                end
                if (run_en_r) begin
                    if (rev_pulse_i && (rev_r != 16'hffff)) begin
                        rev_nxt = inc16(rev_r);
                    end
                    if (tick) begin
                        if (inc16(win_r) >= stall_win_r) begin
                            // a revolution in the closing cycle still counts
                            ev_stall = (rev_nxt < min_revs_r);
                            win_nxt  = '0;
                            rev_nxt  = '0;
                        end else begin
                            win_nxt = inc16(win_r);
                        end
                    end
                end
                if (ev_uv || ev_ov || ev_ovc || ev_stall) begin
                    state_nxt = mfs_pkg::ST_FAULT;
                    rec_nxt   = '0;
                end
            end
            mfs_pkg::ST_FAULT: begin
                if (tick) begin
                    if (inc16(rec_r) >= recov_r) begin
                        state_nxt   = mfs_pkg::ST_INIT;
                        win_nxt     = '0;
                        rev_nxt     = '0;
                        rec_nxt     = '0;
                        pa_seen_nxt = 1'b0;
                        ev_rec      = 1'b1;
                    end else begin
                        rec_nxt = inc16(rec_r);
                    end
                end
            end
            default: begin
                state_nxt = mfs_pkg::ST_INIT;
            end
        endcase
        // off in the same edge as the fault, and through all of init
        predrv_nxt = (state_nxt == mfs_pkg::ST_RUN) && run_en_nxt;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r   <= mfs_pkg::ST_INIT;
            win_r     <= '0;
            rev_r     <= '0;
            rec_r     <= '0;
            pa_seen_r <= 1'b0;
            predrv_r  <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            win_r     <= win_nxt;
            rev_r     <= rev_nxt;
            rec_r     <= rec_nxt;
            pa_seen_r <= pa_seen_nxt;
            predrv_r  <= predrv_nxt;
        end
    end

    // ==========================================================
    // register port, sticky status with set winning over clear
    always_comb begin
        ev_vec        = '0;
        ev_vec[mfs_pkg::IRQ_UV]    = ev_uv;
        ev_vec[mfs_pkg::IRQ_OV]    = ev_ov;
        ev_vec[mfs_pkg::IRQ_STALL] = ev_stall;
        ev_vec[mfs_pkg::IRQ_OVC]   = ev_ovc;
        ev_vec[mfs_pkg::IRQ_RECOV] = ev_rec;
        run_en_nxt    = run_en_r;
        sup_low_nxt   = sup_low_r;
        sup_high_nxt  = sup_high_r;
        cur_ceil_nxt  = cur_ceil_r;
        min_revs_nxt  = min_revs_r;
        stall_win_nxt = stall_win_r;
        recov_nxt     = recov_r;
        int_mask_nxt  = int_mask_r;
        int_sts_nxt   = int_sts_r;
        if (reg_wr_i) begin
            if (hit(reg_addr_i, mfs_pkg::ADDR_CTRL))
                run_en_nxt = reg_wdata_i[mfs_pkg::CTRL_RUN_BIT];
            if (hit(reg_addr_i, mfs_pkg::ADDR_SUP_LOW)) sup_low_nxt = reg_wdata_i[AD-1:0];
            if (hit(reg_addr_i, mfs_pkg::ADDR_SUP_HIGH)) sup_high_nxt = reg_wdata_i[AD-1:0];
            if (hit(reg_addr_i, mfs_pkg::ADDR_CUR_CEIL)) cur_ceil_nxt = reg_wdata_i[AD-1:0];
            if (hit(reg_addr_i, mfs_pkg::ADDR_MIN_REVS)) min_revs_nxt = reg_wdata_i;
            if (hit(reg_addr_i, mfs_pkg::ADDR_STALL_WIN)) stall_win_nxt = reg_wdata_i;
            if (hit(reg_addr_i, mfs_pkg::ADDR_RECOV)) recov_nxt = reg_wdata_i;
            if (hit(reg_addr_i, mfs_pkg::ADDR_INT_MASK)) int_mask_nxt = reg_wdata_i[IW-1:0];
            if (hit(reg_addr_i, mfs_pkg::ADDR_INT_STS))
                int_sts_nxt = int_sts_r & ~reg_wdata_i[IW-1:0];
        end
        int_sts_nxt = int_sts_nxt | ev_vec;
        rdata_nxt   = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                mfs_pkg::ADDR_CTRL:      rdata_nxt = {15'h0000, run_en_r};
                mfs_pkg::ADDR_SUP_LOW:   rdata_nxt = {4'h0, sup_low_r};
                mfs_pkg::ADDR_SUP_HIGH:  rdata_nxt = {4'h0, sup_high_r};
                mfs_pkg::ADDR_CUR_CEIL:  rdata_nxt = {4'h0, cur_ceil_r};
                mfs_pkg::ADDR_MIN_REVS:  rdata_nxt = min_revs_r;
                mfs_pkg::ADDR_STALL_WIN: rdata_nxt = stall_win_r;
                mfs_pkg::ADDR_RECOV:     rdata_nxt = recov_r;
                mfs_pkg::ADDR_STATUS:    rdata_nxt = {13'h0000, predrv_r, state_r};
                mfs_pkg::ADDR_INT_STS:   rdata_nxt = {11'h000, int_sts_r};
                mfs_pkg::ADDR_INT_MASK:  rdata_nxt = {11'h000, int_mask_r};
                mfs_pkg::ADDR_WIN_CNT:   rdata_nxt = win_r;
                mfs_pkg::ADDR_REV_CNT:   rdata_nxt = rev_r;
                mfs_pkg::ADDR_REC_CNT:   rdata_nxt = rec_r;
                default:                 rdata_nxt = '0; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_en_r    <= 1'b0;
            sup_low_r   <= mfs_pkg::SUP_LOW_RST;
            sup_high_r  <= mfs_pkg::SUP_HIGH_RST;
            cur_ceil_r  <= mfs_pkg::CUR_CEIL_RST;
            min_revs_r  <= mfs_pkg::MIN_REVS_RST;
            stall_win_r <= mfs_pkg::STALL_WIN_RST;
            recov_r     <= mfs_pkg::RECOV_RST;
            int_mask_r  <= mfs_pkg::INT_MASK_RST;
            int_sts_r   <= '0;
            rdata_r     <= '0;
        end else begin
            run_en_r    <= run_en_nxt;
            sup_low_r   <= sup_low_nxt;
            sup_high_r  <= sup_high_nxt;
            cur_ceil_r  <= cur_ceil_nxt;
            min_revs_r  <= min_revs_nxt;
            stall_win_r <= stall_win_nxt;
            recov_r     <= recov_nxt;
            int_mask_r  <= int_mask_nxt;
            int_sts_r   <= int_sts_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata_o     = rdata_r;
    assign predrv_en_o     = predrv_r;
    assign fault_o         = (state_r == mfs_pkg::ST_FAULT);
    assign sense_gain_o    = mfs_pkg::SENSE_GAIN_VV;
    assign sense_gain_wr_o = (state_r == mfs_pkg::ST_INIT);
    assign irq_o           = |(int_sts_r & int_mask_r);

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_uv_fault;
        state_r == mfs_pkg::ST_RUN && supply_smp_i.valid && supply_smp_i.data < sup_low_r
            |=> state_r == mfs_pkg::ST_FAULT && !predrv_en_o && int_sts_r[mfs_pkg::IRQ_UV];
    endproperty
    a_uv_fault: assert property (p_uv_fault) else $error("undervoltage not faulted");

    property p_ov_fault;
        state_r == mfs_pkg::ST_RUN && supply_smp_i.valid && supply_smp_i.data > sup_high_r
            |=> state_r == mfs_pkg::ST_FAULT && !predrv_en_o;
    endproperty
    a_ov_fault: assert property (p_ov_fault) else $error("overvoltage not faulted");

    property p_win_step;
        state_r == mfs_pkg::ST_RUN && state_nxt == mfs_pkg::ST_RUN && run_en_r && tick
            && inc16(win_r) < stall_win_r |=> win_r == inc16($past(win_r));
    endproperty
    a_win_step: assert property (p_win_step) else $error("window did not advance");

    property p_rev_count;
        state_r == mfs_pkg::ST_RUN && state_nxt == mfs_pkg::ST_RUN && run_en_r && rev_pulse_i
            && !tick && rev_r != 16'hffff |=> rev_r == inc16($past(rev_r));
    endproperty
    a_rev_count: assert property (p_rev_count) else $error("revolution lost");

    property p_stall;
        state_r == mfs_pkg::ST_RUN && run_en_r && tick && inc16(win_r) >= stall_win_r
            && !rev_pulse_i && rev_r < min_revs_r
            |=> state_r == mfs_pkg::ST_FAULT ##0 int_sts_r[mfs_pkg::IRQ_STALL];
    endproperty
    a_stall: assert property (p_stall) else $error("stall not declared");

    property p_ovc;
        state_r == mfs_pkg::ST_RUN && phase_a_active_i && phase_a_smp_i.valid && !pa_seen_r
            && phase_a_smp_i.data >= cur_ceil_r |=> state_r == mfs_pkg::ST_FAULT;
    endproperty
    a_ovc: assert property (p_ovc) else $error("overcurrent not faulted");

    property p_ceil_wr;
        reg_wr_i && reg_addr_i == mfs_pkg::ADDR_CUR_CEIL
            |=> cur_ceil_r == $past(reg_wdata_i[AD-1:0]);
    endproperty
    a_ceil_wr: assert property (p_ceil_wr) else $error("ceiling not stored");

    property p_init_gain;
        state_r == mfs_pkg::ST_INIT |-> sense_gain_wr_o && sense_gain_o == 3'h5 && !predrv_en_o;
    endproperty
    a_init_gain: assert property (p_init_gain) else $error("init gain wrong");

    property p_recover;
        state_r == mfs_pkg::ST_FAULT && tick && inc16(rec_r) >= recov_r
            |=> state_r == mfs_pkg::ST_INIT ##1 !predrv_en_o;
    endproperty
    a_recover: assert property (p_recover) else $error("no recovery");

    property p_clear_on_exit;
        $past(state_r) == mfs_pkg::ST_FAULT && state_r == mfs_pkg::ST_INIT
            |-> win_r == '0 && rev_r == '0 && rec_r == '0;
    endproperty
    a_clear_on_exit: assert property (p_clear_on_exit) else $error("counters not cleared");

    c_stall: cover property (ev_stall ##1 state_r == mfs_pkg::ST_FAULT);
    c_ovc:   cover property (ev_ovc ##1 fault_o);
    c_recov: cover property (state_r == mfs_pkg::ST_FAULT ##1 state_r == mfs_pkg::ST_INIT);
endmodule

`default_nettype wire

// ---- bench/mfs_drv_model.sv ----
/*
 * far-side model of the gate driver and its sense_amplifier gain setting.
 * assumes it shares core_clk_i and arst_n_i with the supervisor.
 */
`default_nettype none

module mfs_drv_model #(
    parameter int unsigned ACK_DELAY = 12
) (
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [2:0] sense_gain_i,
    input  wire logic       sense_gain_wr_i,
    output logic            sense_gain_ack_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // gain configuration
    int unsigned wait_cnt;

    // only a gain of five is acked, so a wrong code leaves init hanging
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_cnt         <= 0;
            sense_gain_ack_o <= 1'b0;
        end else begin
            sense_gain_ack_o <= 1'b0;
            if (sense_gain_wr_i && sense_gain_i == 3'h5 && !sense_gain_ack_o) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt + 1 >= ACK_DELAY) begin
                    sense_gain_ack_o <= 1'b1;
                    wait_cnt         <= 0;
                end
            end else begin
                wait_cnt <= 0;
            end
        end
    end
endmodule

`default_nettype wire

// ---- bench/mfs_supervisor_tb_top.sv ----
/*
 * self-checking bench of the supervisor: limits, stall, recovery, irq.
 * assumes a tick of 10 core clocks and the gain model as far side.
 */
`default_nettype none

module mfs_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // signals
    logic                     clk = 1'b0;
    logic                     rev = 1'b0;
    logic                     arst_n, reg_wr, reg_rd, pa_act, ack, revs_on;
    logic                     gain_wr, predrv, fault, irq;
    logic [2:0]               gain;
    logic [2:0]               rev_div = '0;
    logic [mfs_pkg::AW-1:0]   reg_addr;
    logic [mfs_pkg::DW-1:0]   reg_wdata, rdata;
    mfs_pkg::mfs_sample_s     sup_smp, pa_smp;
    int                       n_errors = 0;
    int                       n_checks = 0;
    int                       cycles = 0;
    localparam logic [15:0]   RST_TBL [6] = '{16'h02c8, 16'h058f, 16'h012c,
                                              16'h0001, 16'h00c8, 16'h0bb8};

    mfs_supervisor #(.TICK_CYCLES(10)) mfs_supervisor_inst (
        .core_clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(rdata), .supply_smp_i(sup_smp), .phase_a_smp_i(pa_smp),
        .phase_a_active_i(pa_act), .rev_pulse_i(rev), .sense_gain_o(gain),
        .sense_gain_wr_o(gain_wr), .sense_gain_ack_i(ack), .predrv_en_o(predrv),
        .fault_o(fault), .irq_o(irq));

    mfs_drv_model mfs_drv_model_inst (
        .core_clk_i(clk), .arst_n_i(arst_n), .sense_gain_i(gain),
        .sense_gain_wr_i(gain_wr), .sense_gain_ack_o(ack));

    // ==========================================================
    // clock, revolutions, timeout
    always #4 clk = ~clk;

    // a pulse every 8 clocks keeps any window of 3 ticks well fed
    always @(posedge clk) begin
        rev_div <= rev_div + 3'h1;
        rev     <= revs_on && (rev_div == 3'h0);
        cycles  <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // phase a goes active a cycle early and low after, re-arming the judge
    task automatic smp(input bit pa, input logic [11:0] d);
        @(posedge clk);
        pa_act <= pa;
        @(posedge clk);
        if (pa) pa_smp <= '{1'b1, d};
        else sup_smp <= '{1'b1, d};
        @(posedge clk);
        pa_smp.valid  <= 1'b0;
        sup_smp.valid <= 1'b0;
        pa_act        <= 1'b0;
        #1;
    endtask

    task automatic wait_run;
        logic [15:0] v;
        for (int i = 0; i < 400 && predrv !== 1'b1; i++) begin
            @(posedge clk);
            #1;
            if (fault === 1'b0 && predrv === 1'b0) check({15'h0, gain_wr}, 16'h1);
        end
        check({15'h0, predrv}, 16'h1);
        rd(mfs_pkg::ADDR_REC_CNT, v);
        check(v, 16'h0000);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic test_reset_init;
        logic [15:0] v;
        wr(mfs_pkg::ADDR_CTRL, 16'h0001);
        #1;
        check({13'h0, gain}, 16'h0005);
        check({15'h0, predrv}, 16'h0);
        for (int i = 0; i < 6; i++) begin
            rd(4'(i + 1), v);
            check(v, RST_TBL[i]);
        end
        // upper bits of a 12-bit limit are dropped
        wr(mfs_pkg::ADDR_CUR_CEIL, 16'hf12c);
        rd(mfs_pkg::ADDR_CUR_CEIL, v);
        check(v, 16'h012c);
        rd(4'hd, v);
        check(v, 16'h0000);
        wait_run();
        rd(mfs_pkg::ADDR_STATUS, v);
        check(v, 16'h0005);
    endtask

    // at a supply limit passes and one count past it trips; one count under the ceiling passes and the ceiling itself trips
    task automatic fault_case(input bit pa, input logic [11:0] ok_v,
                              input logic [11:0] bad_v, input logic [15:0] bits);
        logic [15:0] v;
        smp(pa, ok_v);
        check({15'h0, fault}, 16'h0);
        smp(pa, bad_v);
        check({14'h0, fault, predrv}, 16'h2);
        rd(mfs_pkg::ADDR_INT_STS, v);
        check(v, bits);
        check({15'h0, irq}, 16'h0);
        wr(mfs_pkg::ADDR_INT_MASK, 16'h001f);
        repeat (2) @(posedge clk);
        #1;
        check({15'h0, irq}, 16'h1);
        wr(mfs_pkg::ADDR_INT_STS, 16'h001f);
        repeat (2) @(posedge clk);
        #1;
        check({15'h0, irq}, 16'h0);
        wr(mfs_pkg::ADDR_INT_MASK, 16'h0000);
        wait_run();
        rd(mfs_pkg::ADDR_INT_STS, v);
        check(v, 16'h0010);
        wr(mfs_pkg::ADDR_INT_STS, 16'h0010);
    endtask

    task automatic test_stall;
        logic [15:0] v;
        wr(mfs_pkg::ADDR_STALL_WIN, 16'h0003);
        repeat (100) @(posedge clk);
        #1;
        check({15'h0, fault}, 16'h0);
        @(posedge clk);
        revs_on <= 1'b0;
        for (int i = 0; i < 70 && fault !== 1'b1; i++) @(posedge clk);
        #1;
        check({14'h0, fault, predrv}, 16'h2);
        rd(mfs_pkg::ADDR_INT_STS, v);
        check(v, 16'h0004);
        wr(mfs_pkg::ADDR_INT_STS, 16'h001f);
        revs_on <= 1'b1;
        wait_run();
    endtask

    // ==========================================================
    // main sequence, recovery kept at 2 ticks
    initial begin
        arst_n    = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        sup_smp   = '0;
        pa_smp    = '0;
        pa_act    = 1'b0;
        revs_on   = 1'b1;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        test_reset_init();
        wr(mfs_pkg::ADDR_RECOV, 16'h0002);
        fault_case(1'b0, 12'h2c8, 12'h2c7, 16'h0001);
        fault_case(1'b0, 12'h58f, 12'h590, 16'h0002);
        fault_case(1'b1, 12'h12b, 12'h12c, 16'h0008);
        test_stall();
        results();
    end
endmodule

`default_nettype wire
